/* design/uecr_map.svh */
`ifndef UECR_MAP_SVH
`define UECR_MAP_SVH

// register offsets (byte addresses)
`define UECR_OFS_PAGE2 8'h00
`define UECR_OFS_PAGE3 8'h04
`define UECR_OFS_CFG 8'h08
`define UECR_OFS_STS 8'h0C
`define UECR_OFS_MASK 8'h10
`define UECR_OFS_EP0 8'h40
`define UECR_EP_DEC_MASK 8'hC3
`define UECR_EP_COUNT 16

// configuration fields
`define UECR_CFG_EYE 7
`define UECR_CFG_OEMON 6
`define UECR_CFG_IDLE 4
`define UECR_CFG_ASUSP 0
`define UECR_CFG_WMASK 8'hD1

// endpoint control fields
`define UECR_EP_LOWSPEED_DIRECT_EN 7
`define UECR_EP_RETRY 6
`define UECR_EP_CONDIS 4
`define UECR_EP_RXEN 3
`define UECR_EP_TXEN 2
`define UECR_EP_STALL 1
`define UECR_EP_HSHK 0
`define UECR_EP_WMASK 8'hDF

// reset values and alignment
`define UECR_RESET_BYTE 8'h00
`define UECR_RESET_VEC 16'h0000
`define UECR_BASE_LOW_ZERO 16'h0000

`endif

/* design/uecr_pkg.sv */
package uecr_pkg;
  typedef logic [7:0] uecr_byte_t;
  typedef logic [7:0] uecr_addr_t;
  typedef logic [31:0] uecr_word_t;
  typedef logic [15:0] uecr_ep_vec_t;
endpackage

/* design/uecr_regs.sv */
`include "uecr_map.svh"

module uecr_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire uecr_pkg::uecr_addr_t reg_addr,
  input wire uecr_pkg::uecr_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output uecr_pkg::uecr_word_t reg_rdata,
  // chip power state and role
  input wire logic chip_idle,
  input wire logic chip_sleep,
  input wire logic host_mode,
  // usb engine
  input wire logic drive_active,
  input wire uecr_pkg::uecr_ep_vec_t stall_event,
  // configuration outputs
  output uecr_pkg::uecr_word_t table_base,
  output logic eye_pattern_test_en,
  output logic oe_monitor,
  output logic usb_halt,
  output logic usb_auto_suspend,
  // endpoint outputs
  output uecr_pkg::uecr_ep_vec_t ep_receive_en,
  output uecr_pkg::uecr_ep_vec_t ep_transmit_en,
  output uecr_pkg::uecr_ep_vec_t ep_setup_accept,
  output uecr_pkg::uecr_ep_vec_t ep_handshake_en,
  output logic lowspeed_direct_en,
  output logic nak_retry_en,
  // interrupt
  output logic irq
);
  import uecr_pkg::*;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  uecr_byte_t table_base_high_byte;
  uecr_byte_t table_base_top_byte;
  uecr_byte_t cfg;
  uecr_ep_vec_t sts;
  uecr_ep_vec_t mask;
  uecr_word_t read_value;
  logic wr_page2;
  logic wr_page3;
  logic wr_cfg;
  logic wr_sts;
  logic wr_mask;
  logic ep_hit;
  uecr_ep_vec_t next_sts;
  wire [7:0] ep_view [`UECR_EP_COUNT];
  wire [15:0] wr_ep;
  wire [15:0] next_rx;
  wire [15:0] next_tx;
  wire [15:0] next_setup;
  wire [15:0] next_hshk;

  assign wr_page2 = reg_wr && (reg_addr == `UECR_OFS_PAGE2);
  assign wr_page3 = reg_wr && (reg_addr == `UECR_OFS_PAGE3);
  assign wr_cfg = reg_wr && (reg_addr == `UECR_OFS_CFG);
  assign wr_sts = reg_wr && (reg_addr == `UECR_OFS_STS);
  assign wr_mask = reg_wr && (reg_addr == `UECR_OFS_MASK);
  assign ep_hit = (reg_addr & `UECR_EP_DEC_MASK) == `UECR_OFS_EP0;

  // upper 24 bits of page, config and endpoint writes are simply dropped
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      table_base_high_byte <= `UECR_RESET_BYTE;
    end else if (wr_page2) begin
      table_base_high_byte <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      table_base_top_byte <= `UECR_RESET_BYTE;
    end else if (wr_page3) begin
      table_base_top_byte <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= `UECR_RESET_BYTE;
    end else if (wr_cfg) begin
      cfg <= reg_wdata[7:0] & `UECR_CFG_WMASK;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `UECR_EP_COUNT; gi++) begin : g_ep
      uecr_byte_t ctl;
      assign wr_ep[gi] = reg_wr && ep_hit && (reg_addr[5:2] == 4'(gi));
      // a stall in the same cycle as a write still sticks
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          ctl <= `UECR_RESET_BYTE;
        end else begin
          if (wr_ep[gi]) begin
            ctl <= reg_wdata[7:0] & `UECR_EP_WMASK;
          end
          if (stall_event[gi]) begin
            ctl[`UECR_EP_STALL] <= 1'b1;
          end
        end
      end
      assign ep_view[gi] = ctl;
      assign next_rx[gi] = ctl[`UECR_EP_RXEN];
      assign next_tx[gi] = ctl[`UECR_EP_TXEN];
      // condis only matters when both directions are on
      assign next_setup[gi] = ctl[`UECR_EP_RXEN] && ctl[`UECR_EP_TXEN]
        && !ctl[`UECR_EP_CONDIS];
      assign next_hshk[gi] = ctl[`UECR_EP_HSHK];
    end
  endgenerate

  // set wins over the write-one clear
  assign next_sts = (sts & ~(wr_sts ? reg_wdata[15:0] : `UECR_RESET_VEC))
    | stall_event;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sts <= `UECR_RESET_VEC;
    end else begin
      sts <= next_sts;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mask <= `UECR_RESET_VEC;
    end else if (wr_mask) begin
      mask <= reg_wdata[15:0];
    end
  end

  always_comb begin
    read_value = '0; // unmapped addresses read zero
    if (reg_addr == `UECR_OFS_PAGE2) begin
      read_value[7:0] = table_base_high_byte;
    end else if (reg_addr == `UECR_OFS_PAGE3) begin
      read_value[7:0] = table_base_top_byte;
    end else if (reg_addr == `UECR_OFS_CFG) begin
      read_value[7:0] = cfg;
    end else if (reg_addr == `UECR_OFS_STS) begin
      read_value[15:0] = sts;
    end else if (reg_addr == `UECR_OFS_MASK) begin
      read_value[15:0] = mask;
    end else if (ep_hit) begin
      read_value[7:0] = ep_view[reg_addr[5:2]];
    end
  end

  // data stands for exactly the cycle after the strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= read_value;
    end else begin
      reg_rdata <= '0;
    end
  end

  // bits 15:9 belong to page one, outside this slice, and stay zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      table_base <= '0;
    end else begin
      table_base <= {table_base_top_byte, table_base_high_byte,
        `UECR_BASE_LOW_ZERO};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      eye_pattern_test_en <= 1'b0;
      oe_monitor <= 1'b0;
      usb_halt <= 1'b0;
      usb_auto_suspend <= 1'b0;
    end else begin
      eye_pattern_test_en <= cfg[`UECR_CFG_EYE];
      oe_monitor <= cfg[`UECR_CFG_OEMON] && drive_active;
      usb_halt <= cfg[`UECR_CFG_IDLE] && chip_idle;
      // without auto suspend, software must suspend through power control
      usb_auto_suspend <= cfg[`UECR_CFG_ASUSP] && chip_sleep;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ep_receive_en <= `UECR_RESET_VEC;
      ep_transmit_en <= `UECR_RESET_VEC;
      ep_setup_accept <= `UECR_RESET_VEC;
      ep_handshake_en <= `UECR_RESET_VEC;
    end else begin
      ep_receive_en <= next_rx;
      ep_transmit_en <= next_tx;
      ep_setup_accept <= next_setup;
      ep_handshake_en <= next_hshk;
    end
  end

  // host bits of endpoints 1..15 are stored but never used
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lowspeed_direct_en <= 1'b0;
      nak_retry_en <= 1'b0;
    end else begin
      lowspeed_direct_en <= host_mode && ep_view[0][`UECR_EP_LOWSPEED_DIRECT_EN];
      nak_retry_en <= host_mode && !ep_view[0][`UECR_EP_RETRY];
    end
  end

  // registered, so the line follows status by one cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sts & mask);
    end
  end

  sequence wr_top_s;
    wr_page3;
  endsequence

  sequence wr_high_s;
    wr_page2;
  endsequence

  sequence ep0_wr_s;
    wr_ep[0] ##1 !wr_ep[0];
  endsequence

  sequence rd_upper_s;
    reg_rd && (reg_addr != `UECR_OFS_STS) && (reg_addr != `UECR_OFS_MASK);
  endsequence

  top_byte_path_a: assert property (
    wr_top_s ##1 !wr_page3 |=> table_base[31:24] == $past(reg_wdata[7:0], 2))
    else $error("top byte did not reach table base");

  high_byte_path_a: assert property (
    wr_high_s ##1 !wr_page2 |=> table_base[23:16] == $past(reg_wdata[7:0], 2))
    else $error("high byte did not reach table base");

  base_aligned_a: assert property (
    table_base[8:0] == 9'h000)
    else $error("table base not 512-byte aligned");

  upper_read_zero_a: assert property (
    rd_upper_s |=> reg_rdata[31:8] == 24'h000000)
    else $error("unimplemented upper bits read nonzero");

  cfg_resv_zero_a: assert property (
    reg_rd && reg_addr == `UECR_OFS_CFG |=> reg_rdata[5] == 1'b0
      && reg_rdata[3:1] == 3'h0)
    else $error("reserved config bits read nonzero");

  rdata_one_cycle_a: assert property (
    reg_rdata != '0 |-> $past(reg_rd))
    else $error("read data outside its cycle");

  eye_test_a: assert property (
    wr_cfg ##1 !wr_cfg |=> eye_pattern_test_en == $past(reg_wdata[7], 2))
    else $error("eye test enable does not follow config");

  oe_monitor_gate_a: assert property (
    oe_monitor |-> $past(cfg[`UECR_CFG_OEMON]) && $past(drive_active))
    else $error("oe monitor active while disabled or idle");

  idle_halt_a: assert property (
    $past(chip_idle) && $past(cfg[`UECR_CFG_IDLE]) |-> usb_halt)
    else $error("module kept running in idle");

  idle_run_a: assert property (
    usb_halt |-> $past(cfg[`UECR_CFG_IDLE]))
    else $error("module halted with stop-in-idle clear");

  sleep_suspend_a: assert property (
    usb_auto_suspend == ($past(chip_sleep) && $past(cfg[`UECR_CFG_ASUSP])))
    else $error("auto suspend wrong on sleep");

  lowspeed_host_a: assert property (
    lowspeed_direct_en |-> $past(host_mode) && $past(ep_view[0][7]))
    else $error("low-speed direct outside host ep0");

  nak_retry_a: assert property (
    $past(host_mode) && !$past(ep_view[0][6]) && $past(reset_n) |-> nak_retry_en)
    else $error("nak retry not enabled");

  nak_retry_dev_a: assert property (
    !host_mode ##1 !host_mode |-> !nak_retry_en && !lowspeed_direct_en)
    else $error("host bits active in device mode");

  setup_block_a: assert property (
    ep_setup_accept[0] |-> $past(ep_view[0][3]) && $past(ep_view[0][2])
      && !$past(ep_view[0][4]))
    else $error("setup accepted while blocked");

  rx_enable_a: assert property (
    ep0_wr_s |=> ep_receive_en[0] == $past(reg_wdata[3], 2))
    else $error("receive enable does not follow write");

  tx_enable_a: assert property (
    ep0_wr_s |=> ep_transmit_en[0] == $past(reg_wdata[2], 2))
    else $error("transmit enable does not follow write");

  stall_flag_a: assert property (
    stall_event[0] |=> ep_view[0][1] && sts[0])
    else $error("stall event not flagged");

  handshake_a: assert property (
    ep0_wr_s |=> ep_handshake_en[0] == $past(reg_wdata[0], 2))
    else $error("handshake enable does not follow write");

  irq_level_a: assert property (
    irq == $past(|(sts & mask)))
    else $error("interrupt does not track masked status");

  // status bits only ever leave through a write-one clear
  sts_sticky_a: assert property (
    !wr_sts |=> (sts & $past(sts)) == $past(sts))
    else $error("status bit lost without a clear");

  sts_clear_a: assert property (
    wr_sts && stall_event == 16'h0000 |=> (sts & $past(reg_wdata[15:0])) == 16'h0000)
    else $error("status bit survived its clear");

  ep_hold_a: assert property (
    !wr_ep[0] && !stall_event[0] |=> ep_view[0] == $past(ep_view[0]))
    else $error("endpoint control changed by itself");

  ep_resv_zero_a: assert property (
    reg_rd && ep_hit |=> reg_rdata[5] == 1'b0)
    else $error("endpoint reserved bit read nonzero");

  setup_dir_a: assert property (
    ep_setup_accept[0] |-> ep_receive_en[0] && ep_transmit_en[0])
    else $error("setup accepted on one-way endpoint");

  rdata_idle_zero_a: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data without a read strobe");

  cfg_written_a: assert property (
    wr_cfg |=> cfg == ($past(reg_wdata[7:0]) & `UECR_CFG_WMASK))
    else $error("config write stored wrong bits");

  page_hold_a: assert property (
    !wr_page3 |=> table_base_top_byte == $past(table_base_top_byte))
    else $error("top byte changed without a write");

endmodule // uecr_regs

/* test/uecr_usb_peer.sv */
module uecr_usb_peer (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // requests from the bench
  input wire logic [3:0] stall_ep,
  input wire logic stall_go,
  input wire logic drive_req,
  // lines toward the block
  output logic drive_active,
  output uecr_pkg::uecr_ep_vec_t stall_event
);
  import uecr_pkg::*;
  // a stall report follows stall_go one cycle later and lasts as many cycles as stall_go is held
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stall_event <= 16'h0000;
    end else begin
      stall_event <= stall_go ? (16'h0001 << stall_ep) : 16'h0000;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      drive_active <= 1'b0;
    end else begin
      drive_active <= drive_req;
    end
  end
endmodule // uecr_usb_peer

/* test/usb_endpoint_config_regs_tb_top.sv */
`include "uecr_map.svh"

module usb_endpoint_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import uecr_pkg::*;
  logic mclk, reset_n, reg_wr, reg_rd, chip_idle, chip_sleep, host_mode;
  logic drive_req, stall_go, drive_active, eye, oe, halt, susp, lsd, nak, irq, rd_q;
  logic [3:0] stall_ep;
  uecr_addr_t reg_addr;
  uecr_word_t reg_wdata, reg_rdata, table_base, v;
  uecr_ep_vec_t stall_event, rxo, txo, sao, hso, rx, tx, sa, hs;
  uecr_byte_t ep_v[16];
  uecr_word_t exp_q[$];
  int fails, tests_run;
  int seed = 32'h62314b6d;

  uecr_regs dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_idle(chip_idle),
    .chip_sleep(chip_sleep), .host_mode(host_mode), .drive_active(drive_active),
    .stall_event(stall_event), .table_base(table_base), .eye_pattern_test_en(eye),
    .oe_monitor(oe), .usb_halt(halt), .usb_auto_suspend(susp), .ep_receive_en(rxo),
    .ep_transmit_en(txo), .ep_setup_accept(sao), .ep_handshake_en(hso),
    .lowspeed_direct_en(lsd), .nak_retry_en(nak), .irq(irq));
  uecr_usb_peer peer (.mclk(mclk), .reset_n(reset_n), .stall_ep(stall_ep),
    .stall_go(stall_go), .drive_req(drive_req), .drive_active(drive_active),
    .stall_event(stall_event));

  always #50 mclk = ~mclk;

  task automatic chk(input string nm, input uecr_word_t seen, input uecr_word_t exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic uecr_addr_t ep_a(input int n);
    return `UECR_OFS_EP0 + 8'(4 * n);
  endfunction

  task automatic wr(input uecr_addr_t a, input uecr_word_t d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // the note is queued when the read is issued; the monitor pops it
  task automatic rd(input uecr_addr_t a, input uecr_word_t e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask

  // outputs are flops fed from registers, so they lag a write by two edges
  task automatic settle;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic stall(input logic [3:0] n);
    @(posedge mclk);
    stall_ep <= n;
    stall_go <= 1'b1;
    @(posedge mclk);
    stall_go <= 1'b0;
    settle;
  endtask

  always @(posedge mclk) rd_q <= reg_rd;

  // read data stand only in the cycle after the strobe
  always @(negedge mclk) begin
    if (rd_q) begin
      chk("read data", reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    chk("watchdog", 32'h1, 32'h0);
    end_sim;
  end

  initial begin
    {mclk, reset_n, reg_wr, reg_rd, chip_idle, chip_sleep, host_mode} = 7'h00;
    {drive_req, stall_go, stall_ep, reg_addr, reg_wdata} = 46'h0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i++) rd(ep_a(i), 32'h0);
    rd(`UECR_OFS_CFG, 32'h0);
    chk("table base", table_base, 32'h0);
    chk("nak retry", 32'(nak), 32'h0);
    v = $random(seed);
    wr(`UECR_OFS_PAGE3, v);
    rd(`UECR_OFS_PAGE3, {24'h0, v[7:0]});
    wr(`UECR_OFS_PAGE2, ~v);
    rd(`UECR_OFS_PAGE2, {24'h0, ~v[7:0]});
    settle;
    chk("table base", table_base, {v[7:0], ~v[7:0], 16'h0000});
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      wr(`UECR_OFS_CFG, v);
      chip_idle <= v[8];
      chip_sleep <= v[9];
      drive_req <= v[10];
      settle;
      chk("eye test", 32'(eye), 32'(v[7]));
      chk("oe monitor", 32'(oe), 32'(v[6] & v[10]));
      chk("idle halt", 32'(halt), 32'(v[4] & v[8]));
      chk("auto suspend", 32'(susp), 32'(v[0] & v[9]));
      rd(`UECR_OFS_CFG, v & 32'h0000_00D1);
    end
    // every config option on at once, so no gate is left to chance
    wr(`UECR_OFS_CFG, 32'h0000_00D1);
    chip_idle <= 1'b1;
    chip_sleep <= 1'b1;
    drive_req <= 1'b1;
    settle;
    chk("oe monitor", 32'(oe), 32'h1);
    chk("idle halt", 32'(halt), 32'h1);
    chk("auto suspend", 32'(susp), 32'h1);
    // without the auto option software has to suspend on its own
    wr(`UECR_OFS_CFG, 32'h0000_0000);
    settle;
    chk("no auto suspend", 32'(susp), 32'h0);
    for (int n = 0; n < 16; n++) begin
      ep_v[n] = 8'($random(seed));
      wr(ep_a(n), {24'hFFFFFF, ep_v[n]});
    end
    for (int n = 0; n < 16; n++) begin
      rd(ep_a(n), {24'h0, ep_v[n] & 8'hDF});
      rx[n] = ep_v[n][3];
      tx[n] = ep_v[n][2];
      sa[n] = ep_v[n][3] & ep_v[n][2] & !ep_v[n][4];
      hs[n] = ep_v[n][0];
    end
    for (int h = 0; h < 2; h++) begin
      @(posedge mclk);
      host_mode <= h[0];
      settle;
      chk("low speed", 32'(lsd), 32'(h[0] & ep_v[0][7]));
      chk("nak retry", 32'(nak), 32'(h[0] & !ep_v[0][6]));
    end
    chk("rx enables", 32'(rxo), 32'(rx));
    chk("tx enables", 32'(txo), 32'(tx));
    chk("setup accept", 32'(sao), 32'(sa));
    chk("handshake", 32'(hso), 32'(hs));
    wr(ep_a(0), 32'h8C);
    settle;
    chk("low speed", 32'(lsd), 32'h1);
    chk("nak retry", 32'(nak), 32'h1);
    chk("setup ep0", 32'(sao[0]), 32'h1);
    wr(ep_a(0), 32'h5C);
    settle;
    chk("low speed", 32'(lsd), 32'h0);
    chk("nak retry", 32'(nak), 32'h0);
    chk("setup ep0", 32'(sao[0]), 32'h0);
    wr(ep_a(3), 32'h0C);
    wr(`UECR_OFS_MASK, 32'h8);
    stall(4'h3);
    chk("irq raised", 32'(irq), 32'h1);
    rd(ep_a(3), 32'h0E);
    rd(`UECR_OFS_STS, 32'h8);
    wr(`UECR_OFS_STS, 32'h8);
    settle;
    chk("irq cleared", 32'(irq), 32'h0);
    stall(4'h5);
    chk("irq masked", 32'(irq), 32'h0);
    rd(`UECR_OFS_STS, 32'h20);
    wr(`UECR_OFS_STS, 32'h20);
    stall(4'h0);
    rd(ep_a(0), 32'h5E);
    rd(`UECR_OFS_STS, 32'h1);
    // unmapped place: write must vanish and read must give zero
    wr(8'h20, 32'hFF);
    rd(8'h20, 32'h0);
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rd(`UECR_OFS_CFG, 32'h0);
    rd(`UECR_OFS_PAGE3, 32'h0);
    rd(ep_a(0), 32'h0);
    settle;
    chk("notes left", 32'(exp_q.size()), 32'h0);
    end_sim;
  end
endmodule // usb_endpoint_config_regs_tb_top
